// ==== logic/wwd_pkg.sv ====
// Package with the register map, field layout and timing constants of the window watchdog.
`default_nettype none
package wwd_pkg;

  // ****************************************
  // Register offsets (byte addresses).
  // ****************************************
  localparam logic [7:0] WWD_CTRL_OFS = 8'h00;
  localparam logic [7:0] WWD_RELOAD_OFS = 8'h04;
  localparam logic [7:0] WWD_WINDOW_OFS = 8'h08;
  localparam logic [7:0] WWD_CMD_OFS = 8'h0C;
  localparam logic [7:0] WWD_COUNT_OFS = 8'h10;
  localparam logic [7:0] WWD_STATUS_OFS = 8'h14;

  // ****************************************
  // Field positions.
  // ****************************************
  localparam int WWD_CTRL_CLKSEL_BIT = 0;
  localparam int WWD_CTRL_PRESEL_BIT = 1;
  localparam int WWD_CMD_SERVICE_BIT = 0;
  localparam int WWD_CMD_DISABLE_BIT = 1;
  localparam int WWD_CMD_ENABLE_BIT = 2;
  localparam int WWD_ST_RUN_BIT = 0;
  localparam int WWD_ST_OVF_BIT = 1;
  localparam int WWD_ST_WIN_BIT = 2;

  // ****************************************
  // Prescaler ratios and reset values.
  // ****************************************
  localparam int WWD_CNT_W = 16;
  localparam int WWD_PRE_W = 14;
  localparam logic [WWD_PRE_W-1:0] WWD_DIV_SLOW_MAX = 14'h3FFF;
  localparam logic [WWD_PRE_W-1:0] WWD_DIV_FAST_MAX = 14'h00FF;
  // 0.13 s at 500 kHz over divide-by-256 is about 254 ticks: reload 0xFF02 counts 254 ticks.
  localparam logic [WWD_CNT_W-1:0] WWD_RELOAD_RST = 16'hFF02;
  localparam logic [WWD_CNT_W-1:0] WWD_WINDOW_RST = 16'h0000;
  localparam logic WWD_CLKSEL_RST = 1'b1;
  localparam logic WWD_PRESEL_RST = 1'b1;

  // ****************************************
  // Pulse width of the reset request in core clock cycles.
  // ****************************************
  localparam int WWD_REQ_NS = 80;
  localparam int WWD_CLK_NS = 10;
  localparam int WWD_REQ_CYC = (WWD_REQ_NS + WWD_CLK_NS - 1) / WWD_CLK_NS;

endpackage
`default_nettype wire

// ==== logic/wwd_top.sv ====
// Window watchdog with APB register access and a reset request output.
`timescale 1ns/100ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wakeup_clk_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic reset_request
);

  typedef enum logic [1:0] {WWD_IDLE, WWD_RUN, WWD_FIRE} wwd_state_e;

  // ****************************************
  // Wake-up clock edge detection.
  // ****************************************
  // The wake-up oscillator arrives as a pin level; two stages, then an edge detector after the second.
  logic wu_s1_q, wu_s2_q, wu_s3_q;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wu_s1_q <= 1'b0;
      wu_s2_q <= 1'b0;
      wu_s3_q <= 1'b0;
    end
    else
    begin
      wu_s1_q <= wakeup_clk_tick;
      wu_s2_q <= wu_s1_q;
      wu_s3_q <= wu_s2_q;
    end
  end
  wire logic wu_rise = wu_s2_q & ~wu_s3_q;

  // ****************************************
  // APB decode.
  // ****************************************
  wire logic apb_acc = psel & penable;
  wire logic wr_en = apb_acc & pwrite;
  wire logic hit_ctrl = (paddr == WWD_CTRL_OFS);
  wire logic hit_rel = (paddr == WWD_RELOAD_OFS);
  wire logic hit_win = (paddr == WWD_WINDOW_OFS);
  wire logic hit_cmd = (paddr == WWD_CMD_OFS);
  wire logic hit_cnt = (paddr == WWD_COUNT_OFS);
  wire logic hit_st = (paddr == WWD_STATUS_OFS);
  wire logic mapped = hit_ctrl | hit_rel | hit_win | hit_cmd | hit_cnt | hit_st;
  // Every access completes in its first access cycle, so the bus never sees a wait state.
  // Unmapped addresses answer with an error and ignore writes; reads of them return zero.
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~mapped;

  // Commands act in the single access cycle only, so a held request cannot repeat them.
  wire logic cmd_wr = wr_en & hit_cmd;
  wire logic cmd_service = cmd_wr & pwdata[WWD_CMD_SERVICE_BIT];
  wire logic cmd_disable = cmd_wr & pwdata[WWD_CMD_DISABLE_BIT];
  wire logic cmd_enable = cmd_wr & pwdata[WWD_CMD_ENABLE_BIT];

  // ****************************************
  // Configuration registers.
  // ****************************************
  // A new prescaler ratio takes full effect once the prescaler has next wrapped.
  logic clksel_q, presel_q;
  logic [WWD_CNT_W-1:0] reload_q, window_q;
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      clksel_q <= WWD_CLKSEL_RST;
      presel_q <= WWD_PRESEL_RST;
      reload_q <= WWD_RELOAD_RST;
      window_q <= WWD_WINDOW_RST;
    end
    else
    begin
      if (wr_en && hit_ctrl)
      begin
        clksel_q <= pwdata[WWD_CTRL_CLKSEL_BIT];
        presel_q <= pwdata[WWD_CTRL_PRESEL_BIT];
      end
      if (wr_en && hit_rel)
        reload_q <= pwdata[WWD_CNT_W-1:0];
      if (wr_en && hit_win)
        window_q <= pwdata[WWD_CNT_W-1:0];
    end
  end

  // ****************************************
  // Prescaler and counter.
  // ****************************************
  wwd_state_e state_q, state_d;
  logic [WWD_PRE_W-1:0] pre_q;
  logic [WWD_CNT_W-1:0] cnt_q;
  logic [3:0] req_cnt_q;
  logic ovf_q, win_q;

  wire logic running = (state_q == WWD_RUN);
  wire logic src_tick = clksel_q ? wu_rise : 1'b1;
  wire logic [WWD_PRE_W-1:0] pre_max = presel_q ? WWD_DIV_FAST_MAX : WWD_DIV_SLOW_MAX;
  wire logic pre_wrap = src_tick & (pre_q == pre_max);
  wire logic cnt_tick = running & pre_wrap;
  // Refresh is forbidden while the count is still below the window boundary.
  wire logic in_window = (cnt_q < window_q);
  wire logic win_fault = running & cmd_service & in_window;
  wire logic good_service = running & cmd_service & ~in_window;
  wire logic overflow = cnt_tick & (cnt_q == {WWD_CNT_W{1'b1}});
  wire logic fault = overflow | win_fault;

  // While the request is being issued the watchdog is frozen and ignores commands.
  // A disable issued in that time is lost, so software must repeat it after the pulse.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      WWD_IDLE:
        if (cmd_enable)
          state_d = WWD_RUN;
      WWD_RUN:
        if (fault)
          state_d = WWD_FIRE;
        else if (cmd_disable)
          state_d = WWD_IDLE;
      WWD_FIRE:
        if (req_cnt_q == 4'(WWD_REQ_CYC - 1))
          state_d = WWD_RUN;
      default:
        state_d = WWD_RUN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state_q <= WWD_RUN;
    else
      state_q <= state_d;
  end

  // A valid service also clears the prescaler, so every interval starts from a full period.
  always_ff @(posedge core_clk)
  begin
    if (!nrst || good_service || !running)
      pre_q <= '0;
    else if (src_tick)
      pre_q <= pre_wrap ? '0 : pre_q + 1'b1;
  end

  // A fault reloads the counter too, so the watchdog runs on at once after the pulse.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cnt_q <= WWD_RELOAD_RST;
    else if (good_service || fault || (state_q == WWD_IDLE && cmd_enable))
      cnt_q <= reload_q;
    else if (cnt_tick)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      req_cnt_q <= '0;
    else if (state_q == WWD_FIRE)
      req_cnt_q <= req_cnt_q + 1'b1;
    else
      req_cnt_q <= '0;
  end

  // Sticky cause flags; a new fault in the clearing cycle wins over the clear.
  wire logic st_clr_ovf = wr_en & hit_st & pwdata[WWD_ST_OVF_BIT];
  wire logic st_clr_win = wr_en & hit_st & pwdata[WWD_ST_WIN_BIT];
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ovf_q <= 1'b0;
      win_q <= 1'b0;
    end
    else
    begin
      ovf_q <= overflow | (ovf_q & ~st_clr_ovf);
      win_q <= win_fault | (win_q & ~st_clr_win);
    end
  end

  // The request is registered so that it reaches the reset logic free of decode glitches.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      reset_request <= 1'b0;
    else
      reset_request <= (state_d == WWD_FIRE);
  end

  // ****************************************
  // Read data.
  // ****************************************
  wire logic [31:0] rd_mux =
    hit_ctrl ? {30'h0, presel_q, clksel_q} :
    hit_rel ? {16'h0, reload_q} :
    hit_win ? {16'h0, window_q} :
    hit_cnt ? {16'h0, cnt_q} :
    hit_st ? {29'h0, win_q, ovf_q, running} : 32'h0;

  // Read data are captured in the setup cycle and stand through the access phase and after it.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule // wwd_top
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the window watchdog.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; $display("Error %s %0h %0h", n, e, s); end end
module tb_top
  import wwd_pkg::*;
;
  logic core_clk, nrst, wakeup_clk_tick, psel, penable, pwrite, pready, pslverr, reset_request, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] rl;
  logic wu_last;
  int fail_count, checks_done, cyc, t, w, rises, b;
  wwd_top u_wwd_top (.core_clk, .nrst, .wakeup_clk_tick, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reset_request);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // The wake-up source toggles at random; it only matters while it is the selected source.
  always @(posedge core_clk)
  begin
    wakeup_clk_tick <= 1'($urandom);
    wu_last <= wakeup_clk_tick;
    if (wakeup_clk_tick && !wu_last)
      rises <= rises + 1;
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge core_clk);
  endtask
  task automatic req_wait(input int lim);
    t = 0;
    w = 0;
    while (reset_request !== 1'b1 && t < lim)
    begin
      @(posedge core_clk);
      t++;
    end
    while (reset_request === 1'b1 && w < 20)
    begin
      @(posedge core_clk);
      w++;
    end
  endtask
  function automatic logic [31:0] dflt_reload();
    return 32'(32'h10000 - $rtoi(0.13 * 500000.0 / 256.0 + 0.5));
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(19));
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset", (i == 0 ? 32'h3 : i == 2 || i == 3 ? 32'h0 : i == 5 ? 32'h1 : dflt_reload()), r)
    end
    apb(1'b0, 8'(8'h18 + 4 * $urandom_range(0, 57)), 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("test reset done");
    rl = 16'($urandom_range(32'h8000, 32'hFFF0));
    apb(1'b1, WWD_CTRL_OFS, 32'h2);
    apb(1'b1, WWD_RELOAD_OFS, {16'h0, rl});
    apb(1'b1, WWD_CMD_OFS, 32'h1);
    apb(1'b0, WWD_COUNT_OFS, 32'h0);
    `CHK("service", {16'h0, rl}, r)
    apb(1'b1, WWD_RELOAD_OFS, 32'hFFFE);
    apb(1'b1, WWD_CMD_OFS, 32'h1);
    req_wait(2000);
    `CHK("overflow time", 1'b1, 1'(t > 505 && t < 516))
    `CHK("pulse", 8, w)
    apb(1'b0, WWD_STATUS_OFS, 32'h0);
    `CHK("overflow flag", 32'h3, r)
    apb(1'b1, WWD_STATUS_OFS, 32'h6);
    apb(1'b1, WWD_WINDOW_OFS, 32'hFFFF);
    apb(1'b1, WWD_CMD_OFS, 32'h1);
    req_wait(6);
    `CHK("window fault", 1'b1, 1'(t < 6))
    apb(1'b0, WWD_STATUS_OFS, 32'h0);
    `CHK("window flag", 32'h5, r)
    $display("test faults done");
    apb(1'b1, WWD_STATUS_OFS, 32'h6);
    apb(1'b1, WWD_WINDOW_OFS, 32'h0);
    apb(1'b1, WWD_CMD_OFS, 32'h2);
    apb(1'b0, WWD_COUNT_OFS, 32'h0);
    rl = r[15:0];
    req_wait(600);
    `CHK("quiet", 600, t)
    apb(1'b0, WWD_COUNT_OFS, 32'h0);
    `CHK("frozen", {16'h0, rl}, r)
    apb(1'b1, WWD_CMD_OFS, 32'h4);
    apb(1'b0, WWD_COUNT_OFS, 32'h0);
    `CHK("enable", 32'hFFFE, r)
    apb(1'b0, WWD_STATUS_OFS, 32'h0);
    `CHK("running", 32'h1, r)
    $display("test disable done");
    apb(1'b1, WWD_CTRL_OFS, 32'h0);
    apb(1'b1, WWD_RELOAD_OFS, 32'hFFFF);
    apb(1'b1, WWD_CMD_OFS, 32'h1);
    req_wait(20000);
    `CHK("slow prescale", 1'b1, 1'(t > 16378 && t < 16390))
    apb(1'b1, WWD_CTRL_OFS, 32'h3);
    apb(1'b1, WWD_CMD_OFS, 32'h1);
    b = rises;
    req_wait(4000);
    `CHK("wake-up ticks", 1'b1, 1'(rises - b > 252 && rises - b < 264))
    $display("test modes done");
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// ==== test/wwd_checker.sv ====
// Assertions on the bus and reset request ports of the watchdog.
`timescale 1ns/100ps
`default_nettype none
module wwd_checker
  import wwd_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic reset_request
);
  wire logic acc = psel && penable;
  wire logic rd = acc && !pwrite;
  wire logic hit = paddr <= WWD_STATUS_OFS && paddr[1:0] == 2'h0;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  AST_READY: assert property (pready) else $error("pready low");
  AST_HIT_OK: assert property (acc && hit |-> !pslverr) else $error("error on mapped");
  AST_MISS_ERR: assert property (acc && !hit |-> pslverr) else $error("no error unmapped");
  AST_IDLE_OK: assert property (!acc |-> !pslverr) else $error("error when idle");
  AST_MISS_RD0: assert property (rd && !hit |-> prdata == 32'h0) else $error("unmapped data");
  AST_CMD_RD0: assert property (rd && paddr == WWD_CMD_OFS |-> prdata == 32'h0) else $error("command data");
  AST_HI_RD0: assert property (rd |-> prdata[31:16] == 16'h0) else $error("upper bits set");
  AST_REQ_LEN: assert property ($rose(reset_request) |-> reset_request [*8] ##1 !reset_request)
    else $error("bad request pulse");
  AST_COV_REQ: cover property ($rose(reset_request));
  AST_COV_MISS: cover property (acc && !hit);
  AST_COV_CMD: cover property (acc && pwrite && paddr == WWD_CMD_OFS);
endmodule // wwd_checker
bind wwd_top wwd_checker u_wwd_checker (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .reset_request);
`default_nettype wire
